// ===== rtl/bank_map.svh
// offsets, field positions, reset values and vectors of the banked address map
`ifndef BANK_MAP_SVH
`define BANK_MAP_SVH
`define OFS_INDIRECT_PORT   7'h00
`define OFS_PC_LOW          7'h02
`define OFS_STATUS          7'h03
`define OFS_POINTER         7'h04
`define OFS_PC_HIGH_LATCH   7'h0a
`define BIT_BANK_HIGH       6
`define BIT_BANK_LOW        5
`define BIT_IRP             7
`define RESET_VECTOR        13'h0000
`define IRQ_VECTOR          13'h0004
`define RST_STATUS          8'h18
`define RST_POINTER         8'h00
`define RST_PC_HIGH_LATCH   8'h00
`define GPR_LOW_START       7'h20
`define GPR_HIGH_START      7'h20
`define GPR_COMMON_START    7'h70
`define SFR_END             7'h1f
`endif

// ===== rtl/bank_map_pkg.sv
// types shared by the address map blocks
package bank_map_pkg;
  typedef enum logic [1:0] {REG_NONE, REG_SFR_CORE, REG_SFR_EXT, REG_GPR}
    region_e;
endpackage

// ===== rtl/banked_memory_address_map.sv
// program counter and banked data memory decode for the cpu core
`include "bank_map.svh"
`timescale 1ns/1ps
`default_nettype none
module banked_memory_address_map #(
  parameter bit BIG_PART = 1'b1
) (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // program side
  input  wire logic        PC_ADV_I,
  input  wire logic        PC_LOAD_I,
  input  wire logic [10:0] PC_TARGET_I,
  input  wire logic        IRQ_TAKE_I,
  output logic      [12:0] PROG_ADDR_O,
  // data side
  input  wire logic        DATA_RD_I,
  input  wire logic        DATA_WR_I,
  input  wire logic [6:0]  DATA_OFS_I,
  input  wire logic [7:0]  DATA_WDATA_I,
  output logic      [7:0]  DATA_RDATA_O,
  output logic      [8:0]  DATA_ADDR_O,
  output logic             EXT_SFR_SEL_O,
  input  wire logic [7:0]  EXT_SFR_RDATA_I,
  output logic      [7:0]  STATUS_O
);
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [7:0]  pch_latch;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [12:0] pc_mask;
  logic [8:0]  full_addr;
  logic [6:0]  ofs;
  logic [1:0]  bank;
  bank_map_pkg::region_e region;
  logic [8:0]  gpr_idx;
  logic [7:0]  gpr_rdata;
  logic        gpr_we;
  logic [7:0]  core_rdata;

  assign pc_mask = BIG_PART ? 13'h1fff : 13'h0fff;

  // direct uses bank bits, offset 00h goes through the pointer
  always_comb
  begin
    if (DATA_OFS_I == `OFS_INDIRECT_PORT)
      full_addr = {st_r.status[`BIT_IRP], st_r.pointer};
    else
      full_addr = {st_r.status[`BIT_BANK_HIGH],
                   st_r.status[`BIT_BANK_LOW], DATA_OFS_I};
  end
  assign ofs  = full_addr[6:0];
  assign bank = full_addr[8:7];

  // region decode; indirect to 00h itself reaches nothing
  always_comb
  begin
    region  = bank_map_pkg::REG_NONE;
    gpr_idx = 9'h000;
    if (ofs == `OFS_INDIRECT_PORT)
      region = bank_map_pkg::REG_NONE;
    else if (ofs == `OFS_PC_LOW || ofs == `OFS_STATUS ||
             ofs == `OFS_POINTER || ofs == `OFS_PC_HIGH_LATCH)
      region = bank_map_pkg::REG_SFR_CORE;
    else if (ofs <= `SFR_END)
      region = bank_map_pkg::REG_SFR_EXT;
    else if (BIG_PART && ofs >= `GPR_COMMON_START)
    begin
      region  = bank_map_pkg::REG_GPR;
      gpr_idx = {2'b00, ofs - `GPR_COMMON_START};
    end
    else if (BIG_PART)
    begin
      region = bank_map_pkg::REG_GPR;
      case (bank)
        2'd0: gpr_idx = 9'h010 + {2'b00, ofs - `GPR_LOW_START};
        2'd1: gpr_idx = 9'h070 + {2'b00, ofs - `GPR_HIGH_START};
        2'd2: gpr_idx = 9'h0c0 + {2'b00, ofs - `GPR_HIGH_START};
        default: gpr_idx = 9'h110 + {2'b00, ofs - `GPR_HIGH_START};
      endcase
    end
    else
    begin
      // small part: banks 2/3 alias banks 0/1 ram
      region  = bank_map_pkg::REG_GPR;
      gpr_idx = bank[0] ? 9'h060 + {2'b00, ofs - `GPR_LOW_START}
                        : {2'b00, ofs - `GPR_LOW_START};
    end
  end

  assign gpr_we = DATA_WR_I && (region == bank_map_pkg::REG_GPR);

  gpr_ram #(.DEPTH(368), .AW(9)) u_ram (
    .REF_CLK_I (REF_CLK_I),
    .RST_I     (RST_I),
    .we_i      (gpr_we),
    .addr_i    (gpr_idx),
    .wdata_i   (DATA_WDATA_I),
    .rdata_o   (gpr_rdata)
  );

  always_comb
  begin
    case (ofs)
      `OFS_PC_LOW:  core_rdata = st_r.pc[7:0];
      `OFS_STATUS:  core_rdata = st_r.status;
      `OFS_POINTER: core_rdata = st_r.pointer;
      default:      core_rdata = st_r.pch_latch;
    endcase
  end

  always_comb
  begin
    case (region)
      bank_map_pkg::REG_SFR_CORE: DATA_RDATA_O = core_rdata;
      bank_map_pkg::REG_SFR_EXT:  DATA_RDATA_O = EXT_SFR_RDATA_I;
      bank_map_pkg::REG_GPR:      DATA_RDATA_O = gpr_rdata;
      default:                    DATA_RDATA_O = 8'h00;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    if (IRQ_TAKE_I)
      st_nxt.pc = `IRQ_VECTOR;
    else if (PC_LOAD_I)
      st_nxt.pc = {st_r.pch_latch[4:3], PC_TARGET_I} & pc_mask;
    else if (PC_ADV_I)
      st_nxt.pc = (st_r.pc + 13'h0001) & pc_mask;
    // a data write to the low pc byte takes over the whole pc
    if (DATA_WR_I && region == bank_map_pkg::REG_SFR_CORE)
    begin
      case (ofs)
        `OFS_PC_LOW:
          st_nxt.pc = {st_r.pch_latch[4:0], DATA_WDATA_I} & pc_mask;
        `OFS_STATUS:  st_nxt.status[7:5] = DATA_WDATA_I[7:5];
        `OFS_POINTER: st_nxt.pointer = DATA_WDATA_I;
        default:      st_nxt.pch_latch = {3'b000, DATA_WDATA_I[4:0]};
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      st_r <= '{pc: `RESET_VECTOR, status: `RST_STATUS,
                pointer: `RST_POINTER, pch_latch: `RST_PC_HIGH_LATCH};
    else
      st_r <= st_nxt;
  end

  // separate fetch and data ports run in the same cycle
  assign PROG_ADDR_O   = st_r.pc;
  assign DATA_ADDR_O   = full_addr;
  assign EXT_SFR_SEL_O = (region == bank_map_pkg::REG_SFR_EXT) &&
                         (DATA_RD_I || DATA_WR_I);
  assign STATUS_O      = st_r.status;

  a_reset_vector: assert property (@(posedge REF_CLK_I)
    $fell(RST_I) |-> PROG_ADDR_O == `RESET_VECTOR)
    else $error("pc not at reset vector");
  a_irq_vector: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    IRQ_TAKE_I |=> PROG_ADDR_O == `IRQ_VECTOR)
    else $error("pc not at interrupt vector");
  a_pc_wrap: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (PROG_ADDR_O & ~pc_mask) == 13'h0000)
    else $error("pc outside fitted range");
  a_pc_step: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    PC_ADV_I && !PC_LOAD_I && !IRQ_TAKE_I && !DATA_WR_I |=>
    PROG_ADDR_O == ((($past(PROG_ADDR_O)) + 13'h0001) & pc_mask))
    else $error("pc did not advance");
  a_bank_select: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DATA_OFS_I != 7'h00 |-> DATA_ADDR_O[8:7] == STATUS_O[6:5])
    else $error("bank bits not applied");
  a_indirect_addr: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DATA_OFS_I == 7'h00 |-> DATA_ADDR_O[7:0] == st_r.pointer)
    else $error("indirect address wrong");
  a_unimpl_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    region == bank_map_pkg::REG_NONE |-> DATA_RDATA_O == 8'h00)
    else $error("unimplemented read not zero");
  a_status_mirror: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    DATA_OFS_I == `OFS_STATUS |-> DATA_RDATA_O == STATUS_O)
    else $error("status mirror wrong");
  a_no_stray_wr: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    region == bank_map_pkg::REG_NONE && DATA_WR_I |=>
    $stable(STATUS_O) && $stable(st_r.pointer))
    else $error("unimplemented write had effect");
endmodule // banked_memory_address_map
`default_nettype wire

// ===== rtl/gpr_ram.sv
// general purpose byte storage held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module gpr_ram #(
  parameter int DEPTH = 368,
  parameter int AW    = 9
) (
  // clock and reset
  input  wire logic          REF_CLK_I,
  input  wire logic          RST_I,
  // access
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem_r [DEPTH];

  // storage has no reset: ram contents are undefined at power up
  always_ff @(posedge REF_CLK_I)
  begin
    if (we_i && (int'(addr_i) < DEPTH))
      mem_r[addr_i] <= wdata_i;
  end

  assign rdata_o = (int'(addr_i) < DEPTH) ? mem_r[addr_i] : 8'h00;

  logic unused_rst;
  assign unused_rst = RST_I;
endmodule // gpr_ram
`default_nettype wire

// ===== tb/sfr_stub.sv
// peripheral register stand-in answering reads the map hands out
`timescale 1ns/1ps
`default_nettype none
module sfr_stub (
  // decode from the map
  input  wire logic       sel_i,
  input  wire logic [8:0] addr_i,
  // data back
  output logic      [7:0] rdata_o
);
  // unselected it shows the inverse, so a stray use never reads right
  assign rdata_o = sel_i ? (addr_i[7:0] ^ 8'h5a) : ~(addr_i[7:0] ^ 8'h5a);
endmodule // sfr_stub
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the banked address map
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        adv = 1'b0, ld = 1'b0, irq = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [10:0] tgt = 11'h000;
  logic [6:0]  ofs = 7'h00, o;
  logic [7:0]  wd = 8'h00, d, rdat, xdat, stat;
  logic [12:0] pc;
  logic [8:0]  addr, k;
  logic        xsel;
  logic [17:0] q[$];
  logic [17:0] e;
  logic [7:0]  mem[logic [8:0]];
  int          err_count = 0, n_checks = 0, seed = 11;

  banked_memory_address_map #(.BIG_PART(1'b1)) u_dut (
    .REF_CLK_I(clk), .RST_I(rst), .PC_ADV_I(adv), .PC_LOAD_I(ld),
    .PC_TARGET_I(tgt), .IRQ_TAKE_I(irq), .PROG_ADDR_O(pc),
    .DATA_RD_I(rd), .DATA_WR_I(wr), .DATA_OFS_I(ofs), .DATA_WDATA_I(wd),
    .DATA_RDATA_O(rdat), .DATA_ADDR_O(addr), .EXT_SFR_SEL_O(xsel),
    .EXT_SFR_RDATA_I(xdat), .STATUS_O(stat));
  sfr_stub u_sfr (.sel_i(xsel), .addr_i(addr), .rdata_o(xdat));

  initial
  forever #2 clk = ~clk;

  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] g);
    n_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // every call drives all inputs except the reset once, so back-to-back calls are safe
  task automatic op(input logic w, input logic r, input logic [6:0] f,
                    input logic [7:0] v, input logic [2:0] p);
    @(posedge clk);
    {wr, rd, ofs, wd, irq, ld, adv} <= {w, r, f, v, p};
    tgt <= {3'h7, v};
  endtask

  task automatic rdx(input logic [6:0] f, input logic [7:0] x,
                     input logic [8:0] a, input logic ca);
    q.push_back({ca, a, x});
    op(1'b0, 1'b1, f, 8'h00, 3'h0);
  endtask

  always @(negedge clk)
    if (rd === 1'b1 && q.size() > 0)
    begin
      e = q.pop_front();
      chk("read data", {8'h00, e[7:0]}, {8'h00, rdat});
      if (e[17])
        chk("file address", {7'h00, e[16:8]}, {7'h00, addr});
    end

  initial
  begin
    #20000;
    err_count++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pc", 16'h0000, {3'h0, pc});
    chk("status", 16'h0018, {8'h00, stat});
    repeat (3) op(1'b0, 1'b0, 7'h00, 8'h00, 3'h1);
    op(1'b1, 1'b0, 7'h0a, 8'h1f, 3'h0);
    @(negedge clk);
    chk("pc", 16'h0003, {3'h0, pc});
    op(1'b0, 1'b0, 7'h00, 8'hff, 3'h6);
    op(1'b0, 1'b0, 7'h00, 8'hff, 3'h2);
    @(negedge clk);
    chk("pc", 16'h0004, {3'h0, pc});
    op(1'b0, 1'b0, 7'h00, 8'h00, 3'h1);
    @(negedge clk);
    chk("pc", 16'h1fff, {3'h0, pc});
    op(1'b1, 1'b0, 7'h03, 8'hff, 3'h0);
    @(negedge clk);
    chk("pc", 16'h0000, {3'h0, pc});
    op(1'b0, 1'b0, 7'h00, 8'h00, 3'h0);
    @(negedge clk);
    chk("status", 16'h00f8, {8'h00, stat});
    $display("program counter test done");
    for (int b = 0; b < 4; b++)
    begin
      op(1'b1, 1'b0, 7'h03, {1'b0, 2'(b), 5'h18}, 3'h0);
      rdx(7'h03, {1'b0, 2'(b), 5'h18}, {2'(b), 7'h03}, 1'b1);
      if (mem.exists(9'h07f))
        rdx(7'h7f, mem[9'h07f], 9'h000, 1'b0);
      for (int i = 0; i < 6; i++)
      begin
        o = i ? 7'h20 + 7'($unsigned($random(seed)) % 96) : 7'h7f;
        d = 8'($random(seed));
        op(1'b1, 1'b0, o, d, 3'h0);
        k = (o >= 7'h70) ? {2'b00, o} : {2'(b), o};
        mem[k] = d;
        rdx(o, d, {2'(b), o}, o < 7'h70);
      end
    end
    $display("bank test done");
    op(1'b1, 1'b0, 7'h03, 8'h20, 3'h0);
    op(1'b1, 1'b0, 7'h04, 8'ha5, 3'h0);
    op(1'b1, 1'b0, 7'h00, 8'h3c, 3'h0);
    rdx(7'h00, 8'h3c, 9'h0a5, 1'b1);
    rdx(7'h25, 8'h3c, 9'h0a5, 1'b1);
    rdx(7'h01, 8'hdb, 9'h081, 1'b1);
    op(1'b1, 1'b0, 7'h04, 8'h00, 3'h0);
    op(1'b1, 1'b0, 7'h00, 8'h77, 3'h0);
    rdx(7'h00, 8'h00, 9'h000, 1'b0);
    rdx(7'h04, 8'h00, 9'h084, 1'b1);
    op(1'b0, 1'b0, 7'h00, 8'h00, 3'h0);
    repeat (2) @(posedge clk);
    $display("indirect test done");
    results();
  end
endmodule // tb
`default_nettype wire
